// *** apfc_pkg.sv ***
package apfc_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 24;
    localparam logic [23:0] BOOT_WORD_ADDR = 24'h010000;
    localparam int CLK_RATE_MHZ = 25;
    localparam real CONFIG_CLOCK_OUT_MAX_PERIOD_NS = 50.0;
    localparam real CONFIG_CLOCK_OUT_TYP_PERIOD_NS = 33.33;
    localparam int RESTART_MIN_NS = 500;
    localparam int RESTART_MIN_CYC = (RESTART_MIN_NS * CLK_RATE_MHZ + 999) / 1000;
    localparam int CONFIG_CLOCK_OUT_DIV = 2;
    localparam logic [31:0] DEFAULT_WORDS = 32'h00092580;
    localparam logic [3:0] JTAG_IR_BOOT_ADDR = 4'h5;
    localparam logic [3:0] JTAG_IR_FLASH_ACCESS = 4'h6;
    localparam int JTAG_IR_W = 4;
    localparam int JTAG_DR_W = 41;
endpackage

// *** apfc_jtag_loader.sv ***
`timescale 1ns/1ps
`default_nettype none
module apfc_jtag_loader (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_boot_load,
    output logic [apfc_pkg::ADDR_W-1:0] o_boot_addr,
    output logic o_flash_req,
    output logic o_flash_we,
    output logic [apfc_pkg::ADDR_W-1:0] o_flash_addr,
    output logic [apfc_pkg::WORD_W-1:0] o_flash_wdata
);
    import apfc_pkg::*;
    typedef enum logic [3:0] {
        S_RESET, S_IDLE, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PAU_DR,
        S_EX2_DR, S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PAU_IR,
        S_EX2_IR, S_UPD_IR
    } tap_type;
    tap_type tap_q, tap_d;
    logic tck_q, tck_rise, tck_fall;
    logic [JTAG_IR_W-1:0] ir_q, irsh_q;
    logic [JTAG_DR_W-1:0] dr_q;
    // TCK is sampled as an ordinary synchronous input, so it must be slow
    assign tck_rise = i_tck & ~tck_q;
    assign tck_fall = ~i_tck & tck_q;
    always_comb begin
        tap_d = tap_q;
        unique case (tap_q)
            S_RESET: tap_d = i_tms ? S_RESET : S_IDLE;
            S_IDLE: tap_d = i_tms ? S_SEL_DR : S_IDLE;
            S_SEL_DR: tap_d = i_tms ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: tap_d = i_tms ? S_EX1_DR : S_SH_DR;
            S_SH_DR: tap_d = i_tms ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: tap_d = i_tms ? S_UPD_DR : S_PAU_DR;
            S_PAU_DR: tap_d = i_tms ? S_EX2_DR : S_PAU_DR;
            S_EX2_DR: tap_d = i_tms ? S_UPD_DR : S_SH_DR;
            S_UPD_DR: tap_d = i_tms ? S_SEL_DR : S_IDLE;
            S_SEL_IR: tap_d = i_tms ? S_RESET : S_CAP_IR;
            S_CAP_IR: tap_d = i_tms ? S_EX1_IR : S_SH_IR;
            S_SH_IR: tap_d = i_tms ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: tap_d = i_tms ? S_UPD_IR : S_PAU_IR;
            S_PAU_IR: tap_d = i_tms ? S_EX2_IR : S_PAU_IR;
            S_EX2_IR: tap_d = i_tms ? S_UPD_IR : S_SH_IR;
            S_UPD_IR: tap_d = i_tms ? S_SEL_DR : S_IDLE;
        endcase
    end
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            tck_q <= 1'b0;
            tap_q <= S_RESET;
        end else begin
            tck_q <= i_tck;
            if (tck_rise) begin
                tap_q <= tap_d;
            end
        end
    end
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            ir_q <= '0;
            irsh_q <= '0;
            dr_q <= '0;
        end else if (tck_rise) begin
            unique case (tap_q)
                S_RESET: ir_q <= '0;
                S_CAP_IR: irsh_q <= {{(JTAG_IR_W-1){1'b0}}, 1'b1};
                S_SH_IR: irsh_q <= {i_tdi, irsh_q[JTAG_IR_W-1:1]};
                S_UPD_IR: ir_q <= irsh_q;
                S_SH_DR: dr_q <= {i_tdi, dr_q[JTAG_DR_W-1:1]};
                default: ;
            endcase
        end
    end
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_tdo <= 1'b0;
        end else if (tck_fall) begin
            o_tdo <= (tap_q == S_SH_IR) ? irsh_q[0] : dr_q[0];
        end
    end
    // Update pulses: boot address load or a flash word access
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_boot_load <= 1'b0;
            o_boot_addr <= BOOT_WORD_ADDR;
            o_flash_req <= 1'b0;
            o_flash_we <= 1'b0;
            o_flash_addr <= '0;
            o_flash_wdata <= '0;
        end else begin
            o_boot_load <= 1'b0;
            o_flash_req <= 1'b0;
            if (tck_rise && tap_q == S_UPD_DR) begin
                if (ir_q == JTAG_IR_BOOT_ADDR) begin
                    o_boot_load <= 1'b1; // RULE_10
                    o_boot_addr <= dr_q[ADDR_W-1:0];
                end else if (ir_q == JTAG_IR_FLASH_ACCESS) begin
                    o_flash_req <= 1'b1; // RULE_11
                    o_flash_we <= dr_q[JTAG_DR_W-1];
                    o_flash_addr <= dr_q[WORD_W+ADDR_W-1:WORD_W];
                    o_flash_wdata <= dr_q[WORD_W-1:0];
                end
            end
        end
    end
endmodule // apfc_jtag_loader
`default_nettype wire

// *** apfc_fetch.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE_01: Other master holds restart low at least 500 ns to reset device.
// RULE_02: Restart forces every flash bus output of the device to high impedance.
// RULE_03: Chip-enable input high keeps the device off the shared flash bus; here a JTAG flash access in ST_JTAG drives it regardless.
// RULE_04: Other master releases bus, then chip enable, then pulses restart.
// RULE_05: Flash wait indication is ignored throughout configuration.
// RULE_06: Configuration clock from internal oscillator, period at most 50 ns; here the 25 MHz clock divided by two gives 80 ns.
// RULE_07: One full 16-bit word captured per configuration clock cycle.
// RULE_08: Typical period 33.33 ns; load time is bits over 16 times period.
// RULE_09: Fetch starts at word address 0x010000 by default.
// RULE_10: Boot address may be replaced through a boundary-scan instruction.
// RULE_11: Flash can be programmed through the four-pin JTAG port.
// RULE_12: Address advances by one per captured word until bitstream done.
module apfc_fetch #(
    parameter logic [31:0] BITSTREAM_WORDS = apfc_pkg::DEFAULT_WORDS
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_config_restart_n,
    input wire logic i_chip_enable_in_n,
    input wire logic i_flash_wait,
    input wire logic [apfc_pkg::WORD_W-1:0] i_flash_data,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_config_clock_out,
    output logic o_config_clock_oe_n,
    output logic [apfc_pkg::ADDR_W-1:0] o_flash_addr,
    output logic o_flash_addr_oe_n,
    output logic [apfc_pkg::WORD_W-1:0] o_flash_data,
    output logic o_flash_data_oe_n,
    output logic o_flash_ce_n,
    output logic o_flash_oe_n,
    output logic o_flash_we_n,
    output logic o_flash_ctl_oe_n,
    output logic [apfc_pkg::WORD_W-1:0] o_word,
    output logic o_word_valid,
    output logic o_config_done
);
    import apfc_pkg::*;
    initial begin
        if (BITSTREAM_WORDS == 32'h0) begin
            $error("BITSTREAM_WORDS must be nonzero");
        end
    end
    // Period with the 25 MHz clock divided by two is 80 ns; a faster
    // oscillator would be needed to meet the 50 ns bound in silicon.
    localparam real CONFIG_CLOCK_OUT_PERIOD_NS = 1000.0 * CONFIG_CLOCK_OUT_DIV / CLK_RATE_MHZ;
    typedef enum logic [2:0] {
        ST_HOLD, ST_WAIT_CE, ST_FETCH, ST_JTAG, ST_DONE
    } state_type;
    state_type state_q;
    logic [7:0] low_cnt_q;
    logic restart_ok;
    logic config_clock_out_q;
    logic [ADDR_W-1:0] boot_q, addr_q;
    logic [31:0] left_q;
    logic jt_boot_load, jt_req, jt_we;
    logic [ADDR_W-1:0] jt_boot, jt_addr;
    logic [WORD_W-1:0] jt_wdata;
    logic jt_busy_q;
    logic drive;
    apfc_jtag_loader u_jtag (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_tck(i_tck),
        .i_tms(i_tms),
        .i_tdi(i_tdi),
        .o_tdo(o_tdo),
        .o_boot_load(jt_boot_load),
        .o_boot_addr(jt_boot),
        .o_flash_req(jt_req),
        .o_flash_we(jt_we),
        .o_flash_addr(jt_addr),
        .o_flash_wdata(jt_wdata)
    );
    // Low pulse must last the minimum before it counts as a restart
    assign restart_ok = (low_cnt_q >= 8'(RESTART_MIN_CYC));
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            low_cnt_q <= '0;
        end else if (i_config_restart_n) begin
            low_cnt_q <= '0;
        end else if (!restart_ok) begin
            low_cnt_q <= low_cnt_q + 8'h01; // RULE_01
        end
    end
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            boot_q <= BOOT_WORD_ADDR; // RULE_09
        end else if (jt_boot_load) begin
            boot_q <= jt_boot; // RULE_10
        end
    end
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= ST_HOLD;
        end else if (restart_ok) begin
            state_q <= ST_HOLD; // RULE_02
        end else begin
            unique case (state_q)
                ST_HOLD: if (i_config_restart_n) begin
                    state_q <= ST_WAIT_CE; // RULE_04
                end
                ST_WAIT_CE: if (!i_chip_enable_in_n) begin
                    state_q <= ST_FETCH; // RULE_03
                end
                ST_FETCH: if (i_chip_enable_in_n) begin
                    state_q <= ST_HOLD; // RULE_03
                end else if (config_clock_out_q && left_q == 32'h1) begin
                    state_q <= ST_DONE;
                end
                ST_DONE: if (jt_req) begin
                    state_q <= ST_JTAG;
                end
                ST_JTAG: if (jt_busy_q) begin
                    state_q <= ST_DONE;
                end
            endcase
        end
    end
    // Divided clock; fetch ignores the flash wait pin by construction
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            config_clock_out_q <= 1'b0;
        end else if (state_q == ST_FETCH) begin
            config_clock_out_q <= ~config_clock_out_q; // RULE_06
        end else begin
            config_clock_out_q <= 1'b0;
        end
    end
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            addr_q <= '0;
            left_q <= '0;
            o_word <= '0;
            o_word_valid <= 1'b0;
        end else begin
            o_word_valid <= 1'b0;
            if (state_q == ST_WAIT_CE) begin
                addr_q <= boot_q;
                left_q <= BITSTREAM_WORDS;
            end else if (state_q == ST_FETCH && config_clock_out_q) begin
                o_word <= i_flash_data; // RULE_07
                o_word_valid <= 1'b1; // RULE_05
                addr_q <= addr_q + 24'h000001; // RULE_12
                left_q <= left_q - 32'h1; // RULE_08
            end else if (state_q == ST_DONE && jt_req) begin
                addr_q <= jt_addr; // RULE_11
            end
        end
    end
    // Two-cycle ST_JTAG strobe for a JTAG flash access, ended by jt_busy_q
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            jt_busy_q <= 1'b0;
            o_flash_data <= '0;
            o_flash_we_n <= 1'b1;
        end else begin
            jt_busy_q <= (state_q == ST_JTAG) && !jt_busy_q;
            if (state_q == ST_DONE && jt_req) begin
                o_flash_data <= jt_wdata;
                o_flash_we_n <= ~jt_we;
            end else if (state_q != ST_JTAG) begin
                o_flash_we_n <= 1'b1;
            end
        end
    end
    assign drive = (state_q == ST_FETCH) || (state_q == ST_JTAG);
    assign o_config_clock_out = config_clock_out_q;
    assign o_config_clock_oe_n = ~(state_q == ST_FETCH); // RULE_02
    assign o_flash_addr = addr_q;
    assign o_flash_addr_oe_n = ~drive; // RULE_02
    assign o_flash_ctl_oe_n = ~drive; // RULE_02
    assign o_flash_data_oe_n = ~((state_q == ST_JTAG) && !o_flash_we_n);
    assign o_flash_ce_n = ~drive;
    assign o_flash_oe_n = ~(drive && o_flash_we_n);
    assign o_config_done = (state_q == ST_DONE);
    logic unused_wait;
    assign unused_wait = i_flash_wait; // RULE_05
endmodule // apfc_fetch
`default_nettype wire

// *** apfc_fetch_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module apfc_fetch_monitor (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_config_restart_n,
    input wire logic i_chip_enable_in_n,
    input wire logic [apfc_pkg::WORD_W-1:0] i_flash_data,
    input wire logic o_config_clock_out,
    input wire logic o_config_clock_oe_n,
    input wire logic [apfc_pkg::ADDR_W-1:0] o_flash_addr,
    input wire logic o_flash_addr_oe_n,
    input wire logic o_flash_ctl_oe_n,
    input wire logic [apfc_pkg::WORD_W-1:0] o_word,
    input wire logic o_word_valid,
    input wire logic o_config_done
);
    import apfc_pkg::*;
    logic [3:0] low_q;
    // Saturates so a long hold never wraps back to zero
    always_ff @(posedge i_mclk or posedge i_reset)
        if (i_reset)
            low_q <= 4'h0;
        else if (i_config_restart_n)
            low_q <= 4'h0;
        else if (low_q != 4'hf)
            low_q <= low_q + 4'h1;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    property p_restart_off;
        low_q >= 4'he |-> o_config_clock_oe_n && o_flash_addr_oe_n
            && o_flash_ctl_oe_n;
    endproperty
    a_restart_off: assert property (p_restart_off)
        else $error("bus driven in restart");
    property p_ce_off;
        i_chip_enable_in_n ##1 i_chip_enable_in_n |-> o_config_clock_oe_n;
    endproperty
    a_ce_off: assert property (p_ce_off)
        else $error("fetch with chip enable high");
    property p_valid_pulse;
        o_word_valid |=> !o_word_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("two words in one clock period");
    property p_capture;
        o_word_valid |-> o_word == $past(i_flash_data, 2);
    endproperty
    a_capture: assert property (p_capture)
        else $error("captured word wrong");
    property p_addr_step;
        o_word_valid |-> o_flash_addr == $past(o_flash_addr, 2) + 24'h1;
    endproperty
    a_addr_step: assert property (p_addr_step)
        else $error("address step wrong");
    property p_clk_toggle;
        !o_config_clock_oe_n ##1 !o_config_clock_oe_n
            |-> o_config_clock_out != $past(o_config_clock_out);
    endproperty
    a_clk_toggle: assert property (p_clk_toggle)
        else $error("config clock stalled");
    property p_clk_idle;
        $past(o_config_clock_oe_n) && o_config_clock_oe_n
            |-> !o_config_clock_out;
    endproperty
    a_clk_idle: assert property (p_clk_idle)
        else $error("config clock runs while idle");
    property p_done_stays;
        o_config_done && i_config_restart_n
            && (low_q < 4'(RESTART_MIN_CYC)) |=> o_config_done;
    endproperty
    a_done_stays: assert property (p_done_stays)
        else $error("done dropped");
endmodule // apfc_fetch_monitor
bind apfc_fetch apfc_fetch_monitor u_mon (
    .i_mclk(i_mclk), .i_reset(i_reset),
    .i_config_restart_n(i_config_restart_n),
    .i_chip_enable_in_n(i_chip_enable_in_n), .i_flash_data(i_flash_data),
    .o_config_clock_out(o_config_clock_out),
    .o_config_clock_oe_n(o_config_clock_oe_n), .o_flash_addr(o_flash_addr),
    .o_flash_addr_oe_n(o_flash_addr_oe_n), .o_flash_ctl_oe_n(o_flash_ctl_oe_n),
    .o_word(o_word), .o_word_valid(o_word_valid), .o_config_done(o_config_done)
);
`default_nettype wire

// *** apfc_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module apfc_flash_model (
    input wire logic [apfc_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_addr_oe_n,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_ctl_oe_n,
    output logic [apfc_pkg::WORD_W-1:0] o_data
);
    import apfc_pkg::*;
    initial o_data = 16'h0000;
    // Contents fold the whole word address so a wrong upper byte shows
    always @(i_addr or i_addr_oe_n or i_ce_n or i_oe_n or i_ctl_oe_n)
        if (!i_addr_oe_n && !i_ctl_oe_n && !i_ce_n && !i_oe_n)
            o_data = i_addr[15:0] ^ {2{i_addr[23:16]}} ^ 16'h5a3c;
        else
            o_data = ~o_data; // Released bus inverts its last data on each input change
endmodule // apfc_flash_model
`default_nettype wire

// *** tb_apfc_fetch.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_apfc_fetch;
    import apfc_pkg::*;
    logic i_mclk, i_reset, i_config_restart_n, i_chip_enable_in_n, i_flash_wait;
    logic [15:0] i_flash_data, o_word;
    logic [23:0] o_flash_addr;
    logic o_config_clock_out, o_config_clock_oe_n, o_flash_addr_oe_n;
    logic o_flash_ce_n, o_flash_oe_n, o_flash_ctl_oe_n, o_word_valid;
    logic o_config_done;
    logic i_tck, i_tms, i_tdi;
    int n_fail, compares;
    initial i_mclk = 1'b0;
    always #20 i_mclk = ~i_mclk;
    apfc_fetch #(.BITSTREAM_WORDS(32'h4)) uut (
        .i_mclk(i_mclk), .i_reset(i_reset),
        .i_config_restart_n(i_config_restart_n),
        .i_chip_enable_in_n(i_chip_enable_in_n), .i_flash_wait(i_flash_wait),
        .i_flash_data(i_flash_data), .i_tck(i_tck), .i_tms(i_tms),
        .i_tdi(i_tdi),
        .o_tdo(), .o_config_clock_out(o_config_clock_out),
        .o_config_clock_oe_n(o_config_clock_oe_n), .o_flash_addr(o_flash_addr),
        .o_flash_addr_oe_n(o_flash_addr_oe_n), .o_flash_data(),
        .o_flash_data_oe_n(), .o_flash_ce_n(o_flash_ce_n),
        .o_flash_oe_n(o_flash_oe_n), .o_flash_we_n(),
        .o_flash_ctl_oe_n(o_flash_ctl_oe_n), .o_word(o_word),
        .o_word_valid(o_word_valid), .o_config_done(o_config_done)
    );
    apfc_flash_model flash (
        .i_addr(o_flash_addr), .i_addr_oe_n(o_flash_addr_oe_n),
        .i_ce_n(o_flash_ce_n), .i_oe_n(o_flash_oe_n),
        .i_ctl_oe_n(o_flash_ctl_oe_n), .o_data(i_flash_data)
    );
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Other master side: 13 cycles is 520 ns, the shortest legal hold here
    task automatic restart_pulse();
        i_config_restart_n = 1'b0;
        repeat (13) @(negedge i_mclk);
        i_config_restart_n = 1'b1;
    endtask
    // Slow TCK: four system clocks per phase so both edges are seen
    task automatic jtag_bit(input logic tms, input logic tdi);
        i_tms = tms;
        i_tdi = tdi;
        repeat (4) @(negedge i_mclk);
        i_tck = 1'b1;
        repeat (4) @(negedge i_mclk);
        i_tck = 1'b0;
    endtask
    task automatic sc_boot_load(input logic [23:0] addr);
        logic [4:0] seq;
        logic [40:0] dr;
        int i;
        seq = 5'b00110;
        dr = {17'h0, addr};
        for (i = 0; i < 5; i++)
            jtag_bit(seq[i], 1'b0);
        for (i = 0; i < 4; i++)
            jtag_bit(i == 3, JTAG_IR_BOOT_ADDR[i]);
        jtag_bit(1'b1, 1'b0);
        jtag_bit(1'b0, 1'b0);
        jtag_bit(1'b1, 1'b0);
        jtag_bit(1'b0, 1'b0);
        jtag_bit(1'b0, 1'b0);
        for (i = 0; i < 41; i++)
            jtag_bit(i == 40, dr[i]);
        jtag_bit(1'b1, 1'b0);
        jtag_bit(1'b0, 1'b0);
        repeat (2) @(negedge i_mclk);
    endtask
    task automatic run_fetch(input logic [23:0] base);
        int k;
        int n;
        k = 0;
        for (n = 0; n < 100 && k < 4; n++) begin
            @(negedge i_mclk);
            i_flash_wait = ~i_flash_wait;
            if (o_word_valid === 1'b1) begin
                chk({8'h0, o_word}, {8'h0, (base[15:0] + k[15:0])
                    ^ {2{base[23:16]}} ^ 16'h5a3c});
                k++;
            end
        end
        chk(k[23:0], 24'h4);
        if (k != 4)
            give_verdict();
        for (n = 0; n < 20 && o_config_done !== 1'b1; n++)
            @(negedge i_mclk);
        chk({23'h0, o_config_done}, 24'h1);
        if (n == 20)
            give_verdict();
    endtask
    task automatic sc_ce_high();
        repeat (30) begin
            @(negedge i_mclk);
            chk({22'h0, o_config_clock_oe_n, o_word_valid}, 24'h2);
        end
    endtask
    task automatic sc_takeover();
        restart_pulse();
        repeat (5) @(negedge i_mclk);
        chk({23'h0, o_config_done}, 24'h0);
        i_chip_enable_in_n = 1'b1;
        restart_pulse();
        chk({20'h0, o_config_clock_oe_n, o_flash_addr_oe_n,
            o_flash_ctl_oe_n, 1'b1}, 24'hf);
        repeat (4) @(negedge i_mclk);
        i_chip_enable_in_n = 1'b0;
        restart_pulse();
        run_fetch(BOOT_WORD_ADDR);
    endtask
    initial begin
        i_reset = 1'b1;
        i_config_restart_n = 1'b1;
        i_chip_enable_in_n = 1'b1;
        i_flash_wait = 1'b0;
        i_tck = 1'b0;
        i_tms = 1'b0;
        i_tdi = 1'b0;
        n_fail = 0;
        compares = 0;
        repeat (16) @(negedge i_mclk);
        i_reset = 1'b0;
        sc_ce_high();
        i_chip_enable_in_n = 1'b0;
        run_fetch(BOOT_WORD_ADDR);
        sc_takeover();
        sc_boot_load(24'h123400);
        restart_pulse();
        run_fetch(24'h123400);
        give_verdict();
    end
endmodule // tb_apfc_fetch
`default_nettype wire
